// ===== hdl/dac_port_pkg.sv
package dac_port_pkg;
  // Channel and word geometry
  localparam int CHANNELS = 5;
  localparam int CODE_WIDTH = 16;
  localparam int WORD_BITS = 32;
  localparam logic [4:0] SHORT_PHASE = 5'h18;
  localparam logic [4:0] LAST_PHASE = 5'h1f;
  // Command word field positions
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 0;
  localparam int REF_OFF_BIT = 0;
  // Command codes
  localparam logic [3:0] CMD_WRITE_A = 4'h0;
  localparam logic [3:0] CMD_WRITE_B = 4'h1;
  localparam logic [3:0] CMD_UPDATE_CH = 4'h2;
  localparam logic [3:0] CMD_UPDATE_ALL = 4'h3;
  localparam logic [3:0] CMD_TOGGLE_SEL = 4'h4;
  localparam logic [3:0] CMD_REF_MODE = 4'h5;
  localparam logic [3:0] ADDR_ALL = 4'hf;
  // Reset values
  localparam logic [CODE_WIDTH-1:0] CODE_RESET = 16'h0000;
  localparam logic [CHANNELS-1:0] TOGGLE_SEL_RESET = 5'h00;
  localparam logic REF_ENABLE_RESET = 1'b1;
  // Pin synchroniser reset levels: {reference_compensation_pin, update, toggle, select}
  localparam logic [3:0] PIN_SYNC_RESET = 4'hf;
  // Settle time after reset before pins are trusted
  localparam int INIT_NS = 30;
  localparam int CLK_NS = 10;
  localparam logic [1:0] INIT_CYCLES = 2'((INIT_NS + CLK_NS - 1) / CLK_NS);
  // Carriers
  typedef logic [CHANNELS-1:0][CODE_WIDTH-1:0] code_bank_type;
  typedef struct packed {
    logic [WORD_BITS-1:0] word;
    logic valid;
  } serial_frame_type;
  typedef enum logic [1:0] {LINK_IDLE, LINK_FRAME, LINK_EXEC} link_state_type;
  typedef enum logic {INIT_WAIT, INIT_RUN} init_state_type;
endpackage

// ===== hdl/dac_bit_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dac_bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Levels in and out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;

  // Two flip-flop synchroniser; stage feeds dout only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage <= RESET_LEVEL;
      dout <= RESET_LEVEL;
    end
    else
    begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/dac_serial_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module dac_serial_shifter (
  // Link clock and reset
  input wire logic sck,
  input wire logic nrst,
  // Link pins
  input wire logic selectLoadLine,
  input wire logic sdi,
  output logic sdoData,
  // Captured frame, static while select/load is high
  output dac_port_pkg::serial_frame_type frame
);
  logic [31:0] shiftReg;
  logic [4:0] bitPhase;
  logic fullWord;
  logic frameOk;
  logic frameReset;
  logic [4:0] next_phase;
  logic next_full;

  // Bit counter is cleared by the frame's own select signal
  assign frameReset = selectLoadLine | ~nrst;
  assign next_phase = 5'(bitPhase + 5'h01);
  assign next_full = fullWord | (bitPhase == dac_port_pkg::LAST_PHASE);
  assign frame = '{word: shiftReg, valid: frameOk};

  // Shift register keeps only the newest 32 bits
  always_ff @(posedge sck or negedge nrst)
  begin
    if (!nrst)
      shiftReg <= '0;
    else if (!selectLoadLine)
      shiftReg <= {shiftReg[30:0], sdi};
  end

  // Bit position within a 32-bit word
  always_ff @(posedge sck or posedge frameReset)
  begin
    if (frameReset)
    begin
      bitPhase <= 5'h00;
      fullWord <= 1'b0;
    end
    else
    begin
      bitPhase <= next_phase;
      fullWord <= next_full;
    end
  end

  // Length check survives the rise of select/load
  always_ff @(posedge sck or negedge nrst)
  begin
    if (!nrst)
      frameOk <= 1'b0;
    else if (!selectLoadLine)
      frameOk <= next_full ? (next_phase == 5'h00) : (next_phase == dac_port_pkg::SHORT_PHASE);
  end

  // Output bit changes on the falling edge
  always_ff @(negedge sck or negedge nrst)
  begin
    if (!nrst)
      sdoData <= 1'b0;
    else
      sdoData <= shiftReg[31];
  end

  property p_shift_in;
    @(posedge sck) disable iff (!nrst) !selectLoadLine |=> shiftReg[0] == $past(sdi);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial input not captured on rising edge");

  property p_echo_delay;
    @(posedge sck) disable iff (!nrst || selectLoadLine) fullWord |-> shiftReg[31] == $past(sdi, 32);
  endproperty
  a_echo_delay: assert property (p_echo_delay)
    else $error("echoed bit not delayed by 32 edges");
endmodule
`default_nettype wire

// ===== hdl/dac_serial_port_update_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module dac_serial_port_update_ctrl (
  // System clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link
  input wire logic sck,
  input wire logic selectLoadLine,
  input wire logic sdi,
  output logic sdoData,
  output logic sdoEnable,
  // Asynchronous control pins
  input wire logic togglePin,
  input wire logic asyncUpdatePin,
  input wire logic referenceCompensationPin,
  // Converter state
  output dac_port_pkg::code_bank_type dacCode,
  output logic [dac_port_pkg::CHANNELS-1:0] toggleSelect,
  output logic refEnable
);
  dac_port_pkg::serial_frame_type frame;
  dac_port_pkg::code_bank_type inputA;
  dac_port_pkg::code_bank_type inputB;
  dac_port_pkg::link_state_type linkState;
  dac_port_pkg::init_state_type initState;
  logic [3:0] pinSync;
  logic selectHigh;
  logic toggleLevel;
  logic updateLevel;
  logic refcompLevel;
  logic prevSelect;
  logic prevToggle;
  logic prevUpdate;
  logic [1:0] initCount;
  logic running;
  logic toggleFall;
  logic toggleRise;
  logic updateFall;
  logic updateFire;
  logic selectRise;
  logic [31:0] cmdWord;
  logic cmdValid;
  logic execNow;
  logic [3:0] cmdCode;
  logic [3:0] cmdAddr;
  logic [dac_port_pkg::CODE_WIDTH-1:0] cmdData;

  // Channel address decode, with an all-channels address
  function automatic logic chanHit(input logic [3:0] addr, input int chan);
    chanHit = (addr == dac_port_pkg::ADDR_ALL) || (addr == 4'(chan));
  endfunction

  // Link side shifting on the serial clock
  dac_serial_shifter shifter (
    .sck(sck),
    .nrst(nrst),
    .selectLoadLine(selectLoadLine),
    .sdi(sdi),
    .sdoData(sdoData),
    .frame(frame)
  );

  // Pins into the system clock domain
  dac_bit_sync #(
    .WIDTH(4),
    .RESET_LEVEL(dac_port_pkg::PIN_SYNC_RESET)
  ) pinSyncer (
    .clk(ref_clk),
    .nrst(nrst),
    .din({referenceCompensationPin, asyncUpdatePin, togglePin, selectLoadLine}),
    .dout(pinSync)
  );

  assign selectHigh = pinSync[0];
  assign toggleLevel = pinSync[1];
  assign updateLevel = pinSync[2];
  assign refcompLevel = pinSync[3];
  assign running = (initState == dac_port_pkg::INIT_RUN);

  // Edge detection on synchronised pins
  assign toggleFall = running && prevToggle && !toggleLevel;
  assign toggleRise = running && !prevToggle && toggleLevel;
  assign updateFall = running && prevUpdate && !updateLevel;
  assign updateFire = updateFall && selectHigh;
  assign selectRise = running && !prevSelect && selectHigh;

  // Fields of the latched command
  assign execNow = (linkState == dac_port_pkg::LINK_EXEC) && cmdValid;
  assign cmdCode = cmdWord[dac_port_pkg::CMD_MSB:dac_port_pkg::CMD_LSB];
  assign cmdAddr = cmdWord[dac_port_pkg::ADDR_MSB:dac_port_pkg::ADDR_LSB];
  assign cmdData = cmdWord[dac_port_pkg::DATA_MSB:dac_port_pkg::DATA_LSB];

  // Start-up settle, then pins are trusted
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      initState <= dac_port_pkg::INIT_WAIT;
      initCount <= 2'h0;
    end
    else
    begin
      case (initState)
        dac_port_pkg::INIT_WAIT:
        begin
          initCount <= 2'(initCount + 2'h1);
          if (initCount == dac_port_pkg::INIT_CYCLES)
            initState <= dac_port_pkg::INIT_RUN;
        end
        dac_port_pkg::INIT_RUN:
          initState <= dac_port_pkg::INIT_RUN;
        default:
          initState <= dac_port_pkg::INIT_WAIT;
      endcase
    end
  end

  // Previous pin levels, loaded while settling to avoid false edges
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prevSelect <= 1'b1;
      prevToggle <= 1'b0;
      prevUpdate <= 1'b1;
    end
    else
    begin
      prevSelect <= selectHigh;
      prevToggle <= toggleLevel;
      prevUpdate <= updateLevel;
    end
  end

  // Frame tracking; the word is static once select/load is high
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      linkState <= dac_port_pkg::LINK_IDLE;
      cmdWord <= '0;
      cmdValid <= 1'b0;
    end
    else
    begin
      case (linkState)
        dac_port_pkg::LINK_IDLE:
        begin
          if (running && !selectHigh)
            linkState <= dac_port_pkg::LINK_FRAME;
        end
        dac_port_pkg::LINK_FRAME:
        begin
          if (selectRise)
          begin
            cmdWord <= frame.word;
            cmdValid <= frame.valid;
            linkState <= dac_port_pkg::LINK_EXEC;
          end
        end
        dac_port_pkg::LINK_EXEC:
        begin
          cmdValid <= 1'b0;
          linkState <= selectHigh ? dac_port_pkg::LINK_IDLE : dac_port_pkg::LINK_FRAME;
        end
        default:
          linkState <= dac_port_pkg::LINK_IDLE;
      endcase
    end
  end

  // Serial output driven only inside a frame
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      sdoEnable <= 1'b0;
    else
      sdoEnable <= running && !selectHigh;
  end

  // Input registers written by commands
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      inputA <= {dac_port_pkg::CHANNELS{dac_port_pkg::CODE_RESET}};
      inputB <= {dac_port_pkg::CHANNELS{dac_port_pkg::CODE_RESET}};
    end
    else if (execNow)
    begin
      for (int i = 0; i < dac_port_pkg::CHANNELS; i++)
      begin
        if (cmdCode == dac_port_pkg::CMD_WRITE_A && chanHit(cmdAddr, i))
          inputA[i] <= cmdData;
        if (cmdCode == dac_port_pkg::CMD_WRITE_B && chanHit(cmdAddr, i))
          inputB[i] <= cmdData;
      end
    end
  end

  // Toggle select bits
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      toggleSelect <= dac_port_pkg::TOGGLE_SEL_RESET;
    else if (execNow && cmdCode == dac_port_pkg::CMD_TOGGLE_SEL)
      toggleSelect <= cmdData[dac_port_pkg::CHANNELS-1:0];
  end

  // Converter registers; async update beats toggle beats command
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      dacCode <= {dac_port_pkg::CHANNELS{dac_port_pkg::CODE_RESET}};
    else
    begin
      for (int i = 0; i < dac_port_pkg::CHANNELS; i++)
      begin
        if (updateFire)
          dacCode[i] <= inputA[i];
        else if (toggleFall && toggleSelect[i])
          dacCode[i] <= inputA[i];
        else if (toggleRise && toggleSelect[i])
          dacCode[i] <= inputB[i];
        else if (execNow && (cmdCode == dac_port_pkg::CMD_UPDATE_ALL
                 || (cmdCode == dac_port_pkg::CMD_UPDATE_CH && chanHit(cmdAddr, i))))
          dacCode[i] <= inputA[i];
      end
    end
  end

  // Reference enable: strap at start, then mode command
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      refEnable <= dac_port_pkg::REF_ENABLE_RESET;
    else if (initState == dac_port_pkg::INIT_WAIT && initCount == dac_port_pkg::INIT_CYCLES)
      refEnable <= refcompLevel;
    else if (execNow && cmdCode == dac_port_pkg::CMD_REF_MODE)
      refEnable <= ~cmdData[dac_port_pkg::REF_OFF_BIT];
  end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Per-channel checks of converter loads
  for (genvar g = 0; g < dac_port_pkg::CHANNELS; g++)
  begin : chanCheck
    property p_toggle_a;
      toggleFall && !updateFire && toggleSelect[g] |=> dacCode[g] == $past(inputA[g]);
    endproperty
    a_toggle_a: assert property (p_toggle_a)
      else $error("falling toggle did not load input A");

    property p_toggle_b;
      toggleRise && !updateFire && toggleSelect[g] |=> dacCode[g] == $past(inputB[g]);
    endproperty
    a_toggle_b: assert property (p_toggle_b)
      else $error("rising toggle did not load input B");

    property p_toggle_keep;
      (toggleFall || toggleRise) && !toggleSelect[g] && !updateFire && !execNow
        |=> $stable(dacCode[g]);
    endproperty
    a_toggle_keep: assert property (p_toggle_keep)
      else $error("unselected channel changed on toggle");

    property p_update_copy;
      updateFire |=> dacCode[g] == $past(inputA[g]);
    endproperty
    a_update_copy: assert property (p_update_copy)
      else $error("async update did not copy input register");
  end

  property p_update_gated;
    updateFall && !selectHigh && !toggleFall && !toggleRise && !execNow |=> $stable(dacCode);
  endproperty
  a_update_gated: assert property (p_update_gated)
    else $error("async update acted during a frame");

  property p_sdo_off;
    running && selectHigh |=> !sdoEnable;
  endproperty
  a_sdo_off: assert property (p_sdo_off)
    else $error("serial output driven with select high");

  property p_sdo_on;
    running && !selectHigh |=> sdoEnable;
  endproperty
  a_sdo_on: assert property (p_sdo_on)
    else $error("serial output not driven in frame");

  property p_exec_after_rise;
    execNow |-> $past(selectRise) && $past(frame.valid);
  endproperty
  a_exec_after_rise: assert property (p_exec_after_rise)
    else $error("command executed without select rise");

  property p_strap_off;
    $rose(running) && !$past(refcompLevel) |-> !refEnable;
  endproperty
  a_strap_off: assert property (p_strap_off)
    else $error("reference enabled despite grounded strap");

  property p_ref_default;
    $rose(running) && $past(refcompLevel) |-> refEnable;
  endproperty
  a_ref_default: assert property (p_ref_default)
    else $error("reference not enabled by default");

  // Mode command drives the reference enable
  property p_ref_mode;
    execNow && cmdCode == dac_port_pkg::CMD_REF_MODE
      |=> refEnable == !$past(cmdData[dac_port_pkg::REF_OFF_BIT]);
  endproperty
  a_ref_mode: assert property (p_ref_mode)
    else $error("reference mode command not applied");

  // Select command loads the toggle select bits
  property p_sel_load;
    execNow && cmdCode == dac_port_pkg::CMD_TOGGLE_SEL
      |=> toggleSelect == $past(cmdData[dac_port_pkg::CHANNELS-1:0]);
  endproperty
  a_sel_load: assert property (p_sel_load)
    else $error("toggle select bits not loaded");

  // One execution per captured frame
  property p_exec_once;
    execNow |=> !execNow;
  endproperty
  a_exec_once: assert property (p_exec_once)
    else $error("command executed twice for one frame");

  property p_settle_quiet;
    !running |=> $stable(dacCode) && $stable(toggleSelect);
  endproperty
  a_settle_quiet: assert property (p_settle_quiet)
    else $error("converter state changed before start-up settled");

  c_exec: cover property (execNow);
  c_toggle: cover property (toggleFall ##[1:400] toggleRise);
  c_update: cover property (updateFire);
  c_bad_frame: cover property (selectRise && !frame.valid);
endmodule
`default_nettype wire

// ===== test/dac_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dac_host_model (
  // Link clock and request
  input wire logic linkClk,
  input wire logic go,
  input wire logic [63:0] word,
  input wire logic [6:0] nBits,
  input wire logic [2:0] gap,
  // Serial pins
  output logic sck,
  output logic selectLoadLine,
  output logic sdi,
  input wire logic sdo,
  // Status and echo
  output logic busy,
  output logic [63:0] echo
);
  logic sckEn;
  int i;
  // Gated clock stands still outside frames
  assign sck = sckEn & linkClk;
  initial
  begin
    sckEn = 1'b0;
    selectLoadLine = 1'b1;
    sdi = 1'b0;
    busy = 1'b0;
    echo = '0;
  end
  // Echoed bits taken on the rising edge
  always @(posedge sck)
  begin
    echo <= {echo[62:0], sdo};
  end
  // One frame per request, MSB first, optional idle gap between bits
  always
  begin
    wait (go === 1'b1);
    busy = 1'b1;
    @(negedge linkClk);
    selectLoadLine = 1'b0;
    repeat (3) @(negedge linkClk);
    for (i = nBits - 1; i >= 0; i--)
    begin
      sdi = word[i];
      sckEn = 1'b1;
      @(negedge linkClk);
      sckEn = 1'b0;
      repeat (gap) @(negedge linkClk);
    end
    @(negedge linkClk);
    selectLoadLine = 1'b1;
    sdi = ~sdi; // Released line shows no stale value
    wait (go === 1'b0);
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// ===== test/test_dac_serial_port_update_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_dac_serial_port_update_ctrl;
  localparam int CH = dac_port_pkg::CHANNELS;
  localparam int LIMIT = 20000;
  logic ref_clk = 1'b0;
  logic linkClk = 1'b0;
  logic nrst = 1'b0;
  logic togglePin = 1'b1;
  logic asyncUpdatePin = 1'b1;
  logic referenceCompensationPin = 1'b1;
  logic go = 1'b0;
  logic [63:0] word = '0;
  logic [6:0] nBits = 7'h20;
  logic [2:0] gap = 3'h0;
  logic sck;
  logic selectLoadLine;
  logic sdi;
  logic sdoData;
  logic sdoEnable;
  wire sdo;
  logic busy;
  logic [63:0] echo;
  dac_port_pkg::code_bank_type dacCode;
  logic [CH-1:0] toggleSelect;
  logic refEnable;
  dac_port_pkg::code_bank_type expA = '0;
  dac_port_pkg::code_bank_type expB = '0;
  dac_port_pkg::code_bank_type expCode = '0;
  logic [CH-1:0] expSel = '0;
  logic expRef = 1'b1;
  logic [85:0] lastExp = 86'h1;
  logic [85:0] notes[$];
  logic [85:0] seen;
  logic [85:0] cur;
  logic [63:0] hi;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 32'h771b4e31;
  int k;
  // Clocks: link clock unrelated in phase to the system clock
  always #5 ref_clk = ~ref_clk;
  always #16 linkClk = ~linkClk;
  // Bench resolves the serial output wire
  assign sdo = sdoEnable ? sdoData : 1'bz;
  assign cur = {dacCode, toggleSelect, refEnable};
  dac_serial_port_update_ctrl u_dut (.ref_clk(ref_clk), .nrst(nrst), .sck(sck),
    .selectLoadLine(selectLoadLine), .sdi(sdi), .sdoData(sdoData), .sdoEnable(sdoEnable),
    .togglePin(togglePin), .asyncUpdatePin(asyncUpdatePin),
    .referenceCompensationPin(referenceCompensationPin), .dacCode(dacCode),
    .toggleSelect(toggleSelect), .refEnable(refEnable));
  dac_host_model u_host (.linkClk(linkClk), .go(go), .word(word), .nBits(nBits),
    .gap(gap), .sck(sck), .selectLoadLine(selectLoadLine), .sdi(sdi), .sdo(sdo),
    .busy(busy), .echo(echo));
  task automatic complete_run;
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic compareState(input logic [85:0] got, input logic [85:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t state got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic compareBit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t pin got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic compareWord(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t echo got %h exp %h", $time, got, exp);
    end
  endtask
  // Any change of the converter state takes the oldest note
  always @(negedge ref_clk)
  begin
    if (nrst === 1'b1 && cur !== seen)
    begin
      if (notes.size() == 0)
        compareState(cur, seen);
      else
        compareState(cur, notes.pop_front());
    end
    seen = cur;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors++;
      complete_run;
    end
  end
  function automatic logic [63:0] mk(input logic [3:0] c, input logic [3:0] a,
    input logic [15:0] d);
    return {40'h0, c, a, d};
  endfunction
  task automatic noteState;
    logic [85:0] e;
    e = {expCode, expSel, expRef};
    if (e !== lastExp)
      notes.push_back(e);
    lastExp = e;
  endtask
  task automatic applyCmd(input logic [23:0] c);
    int i;
    for (i = 0; i < CH; i++)
      if (c[19:16] == 4'hf || c[19:16] == i)
        case (c[23:20])
          dac_port_pkg::CMD_WRITE_A: expA[i] = c[15:0];
          dac_port_pkg::CMD_WRITE_B: expB[i] = c[15:0];
          dac_port_pkg::CMD_UPDATE_CH: expCode[i] = expA[i];
          default: ;
        endcase
    if (c[23:20] == dac_port_pkg::CMD_UPDATE_ALL)
      expCode = expA;
    if (c[23:20] == dac_port_pkg::CMD_TOGGLE_SEL)
      expSel = c[CH-1:0];
    if (c[23:20] == dac_port_pkg::CMD_REF_MODE)
      expRef = ~c[0];
  endtask
  // Only the last command word of a legal length executes
  task automatic sendFrame(input logic [63:0] w, input logic [6:0] n, input logic [2:0] g);
    if (n == 7'h18 || n == 7'h20 || n == 7'h40)
      applyCmd(w[23:0]);
    noteState;
    @(posedge ref_clk);
    word <= w;
    nBits <= n;
    gap <= g;
    go <= 1'b1;
    wait (busy === 1'b1);
    @(posedge ref_clk);
    go <= 1'b0;
    wait (busy === 1'b0);
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic setPins(input logic t, input logic u);
    @(posedge ref_clk);
    togglePin <= t;
    asyncUpdatePin <= u;
    repeat (110) @(posedge ref_clk);
  endtask
  task automatic toggleTo(input logic v);
    int i;
    for (i = 0; i < CH; i++)
      if (expSel[i])
        expCode[i] = v ? expB[i] : expA[i];
    noteState;
    setPins(v, 1'b1);
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    compareState(cur, 86'h1);
    nrst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    for (k = 0; k < CH; k++)
      sendFrame(mk(dac_port_pkg::CMD_WRITE_A, 4'(k), 16'($random(seed))), 7'h20, 3'(k));
    sendFrame(mk(dac_port_pkg::CMD_WRITE_B, 4'hf, 16'($random(seed))), 7'h18, 3'h0);
    sendFrame(mk(dac_port_pkg::CMD_UPDATE_ALL, 4'h0, 16'h0), 7'h1f, 3'h0);
    sendFrame(mk(dac_port_pkg::CMD_UPDATE_ALL, 4'h0, 16'h0), 7'h20, 3'h0);
    sendFrame(mk(dac_port_pkg::CMD_TOGGLE_SEL, 4'h0, 16'h0015), 7'h18, 3'h0);
    toggleTo(1'b0);
    toggleTo(1'b1);
    toggleTo(1'b0);
    sendFrame(mk(dac_port_pkg::CMD_WRITE_A, 4'h1, 16'($random(seed))), 7'h20, 3'h0);
    fork
      sendFrame(mk(dac_port_pkg::CMD_WRITE_B, 4'h3, 16'($random(seed))), 7'h20, 3'h3);
      begin
        wait (selectLoadLine === 1'b0);
        repeat (20) @(posedge ref_clk);
        compareBit(sdoEnable, 1'b1);
        asyncUpdatePin <= 1'b0;
        repeat (10) @(posedge ref_clk);
        asyncUpdatePin <= 1'b1;
      end
    join
    expCode = expA;
    noteState;
    setPins(1'b0, 1'b0);
    setPins(1'b0, 1'b1);
    sendFrame(mk(dac_port_pkg::CMD_WRITE_A, 4'h0, 16'($random(seed))), 7'h20, 3'h0);
    sendFrame(mk(dac_port_pkg::CMD_UPDATE_CH, 4'h0, 16'h0), 7'h20, 3'h0);
    sendFrame(mk(dac_port_pkg::CMD_WRITE_A, 4'h2, 16'($random(seed))), 7'h20, 3'h0);
    hi = mk(dac_port_pkg::CMD_UPDATE_ALL, 4'h0, 16'h0);
    sendFrame({hi[31:0], 32'(mk(dac_port_pkg::CMD_WRITE_B, 4'h2, 16'h5a5a))}, 7'h40, 3'h0);
    compareWord(echo[31:0], hi[31:0]);
    compareBit(sdoEnable, 1'b0);
    sendFrame(mk(dac_port_pkg::CMD_UPDATE_ALL, 4'h0, 16'h0), 7'h18, 3'h0);
    sendFrame(mk(dac_port_pkg::CMD_REF_MODE, 4'h0, 16'h0001), 7'h20, 3'h0);
    sendFrame(mk(dac_port_pkg::CMD_REF_MODE, 4'h0, 16'h0000), 7'h18, 3'h0);
    // Second start-up with the compensation strap low
    referenceCompensationPin <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    expA = '0;
    expB = '0;
    expCode = '0;
    expSel = '0;
    expRef = 1'b0;
    lastExp = 86'h1;
    noteState;
    nrst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    compareBit(notes.size() == 0, 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
